// ### include/irq_unit_pkg.sv
`default_nettype none
package irq_unit_pkg;
  // Register addressing: module specifier and index within module
  localparam logic [3:0]  MOD_SYS      = 4'h8;
  localparam logic [3:0]  MOD_VEC      = 4'hd;
  localparam logic [4:0]  IDX_CTRL     = 5'h05;
  localparam logic [4:0]  IDX_MASK     = 5'h06;
  localparam logic [4:0]  IDX_IDENT    = 5'h0b;
  localparam logic [4:0]  IDX_VECTOR   = 5'h02;
  // Reset values
  localparam logic [15:0] VECTOR_RST   = 16'h0000;
  localparam logic [7:0]  BYTE_RST     = 8'h00;
  // Control field positions
  localparam int          GIE_BIT      = 0;
  localparam int          SERVICE_BIT  = 1;
  localparam int          SPARE_BIT    = 5;
  // Module mask / identification bit positions
  localparam int          SYS_BIT      = 7;
  localparam int          M0_BIT       = 0;
  localparam int          M1_BIT       = 1;
  localparam int          M2_BIT       = 2;
  localparam int          M3_BIT       = 3;
  localparam int          M5_BIT       = 5;
  // Source numbering: externals first, then internal events
  localparam int          N_EXT        = 8;
  localparam int          N_INT        = 27;
  localparam int          N_SRC        = N_EXT + N_INT;
  localparam int          SRC_WDOG     = 8;
  localparam int          SRC_SCHED    = 20;
  localparam int          SRC_UART     = 25;
  localparam int          SRC_ANALOG   = 28;
  // Hardware return stack
  localparam int          STACK_DEPTH  = 16;
  localparam int          STACK_W      = 16;
  // Crystal warm-up after stop, in microseconds (plain default)
  localparam int          CLK_NS       = 8;
  localparam int          WARMUP_US    = 1000;
  localparam int          WARMUP_CYC   = WARMUP_US * 1000 / CLK_NS;

  // Stop-mode sequencer states
  typedef enum logic [2:0] {
    ST_RUN    = 3'b001,
    ST_HALT   = 3'b010,
    ST_WARM   = 3'b100
  } stop_state_t;

  // Register port request from the core
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [3:0]  modsel;
    logic [4:0]  idx;
    logic [15:0] wdata;
  } reg_req_t;

  // Which module mask bit gates a given source
  function automatic int src_mask_bit(input int s);
    if (s < N_EXT) return M0_BIT;
    if (s == SRC_WDOG) return SYS_BIT;
    if (s < SRC_SCHED) return M2_BIT;
    if (s < SRC_UART) return M1_BIT;
    if (s < SRC_ANALOG) return M3_BIT;
    return M5_BIT;
  endfunction : src_mask_bit
endpackage : irq_unit_pkg
`default_nettype wire

// ### rtl/single_vector_interrupt_unit.sv
`timescale 1ns/1ps
`default_nettype none
module single_vector_interrupt_unit
  import irq_unit_pkg::*;
#(
  parameter int WARMUP_CYCLES = WARMUP_CYC  // Shorten in simulation
) (
  input  wire logic                clk,
  input  wire logic                rstn,
  input  wire reg_req_t            reg_req,
  output logic [15:0]              reg_rdata,
  input  wire logic [N_EXT-1:0]    ext_pin,
  input  wire logic [N_INT-1:0]    int_event,
  input  wire logic [N_SRC-1:0]    src_enable,
  input  wire logic [N_SRC-1:0]    flag_clear,
  input  wire logic                irq_take,
  input  wire logic [15:0]         ret_addr_in,
  input  wire logic                return_from_handler_instr,
  input  wire logic                stop_set,
  input  wire logic                xtal_wait,
  output logic                     irq_req,
  output logic [15:0]              vector_pc,
  output logic [15:0]              ret_addr_out,
  output logic [N_SRC-1:0]         flags,
  output logic                     clocks_halted,
  output logic                     on_rc_osc
);

  localparam int SPW = $clog2(STACK_DEPTH);
  localparam int WCW = $clog2(WARMUP_CYCLES + 1);

  logic [N_EXT-1:0]   ext_s1;         // First synchroniser stage
  logic [N_EXT-1:0]   ext_s2;         // Second stage
  logic [N_EXT-1:0]   ext_s3;         // Delayed copy for edge detect
  logic [N_EXT-1:0]   ext_rise;       // One-cycle external event
  logic [N_SRC-1:0]   events;         // All source events
  logic [N_SRC-1:0]   src_gate;       // Module mask seen per source
  logic [N_SRC-1:0]   pend;           // Fully enabled pending flags
  logic [7:0]         module_mask;    // Module mask register
  logic               global_irq_enable;
  logic               in_service_flag;
  logic               control_bit5_field;
  logic [7:0]         source_identification;
  logic [7:0]         next_ident;
  logic [15:0]        handler_vector;
  logic [15:0]        stack_mem [STACK_DEPTH];
  logic [SPW-1:0]     sp;             // Next free stack slot
  stop_state_t        stop_state;
  logic [WCW-1:0]     warm_cnt;
  logic               wake;
  logic               ctrl_wr;
  logic               mask_wr;
  logic               vec_wr;
  logic [15:0]        bottom_push;    // Copy of stack slot 0 for the return check

  // Write strobes per register; reads decode in the read port
  // Unmapped writes match none of these and are dropped
  assign ctrl_wr = reg_req.wr && reg_req.modsel == MOD_SYS && reg_req.idx == IDX_CTRL;
  assign mask_wr = reg_req.wr && reg_req.modsel == MOD_SYS && reg_req.idx == IDX_MASK;
  assign vec_wr  = reg_req.wr && reg_req.modsel == MOD_VEC && reg_req.idx == IDX_VECTOR;

  // Pins come from outside the clock domain: two flops first
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ext_s1 <= '0;
      ext_s2 <= '0;
      ext_s3 <= '0;
    end else begin
      ext_s1 <= ext_pin;
      ext_s2 <= ext_s1;
      ext_s3 <= ext_s2;
    end
  end

  // Rising edge only; polarity selection lives in the port logic
  assign ext_rise = ext_s2 & ~ext_s3;
  // Internal events: watchdog, timers, SPI, UART, LIN, analog, supply
  assign events = {int_event, ext_rise};

  // Sticky flags; a new event beats a clear in the same cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      flags <= '0;
    end else begin
      flags <= (flags & ~flag_clear) | events;
    end
  end

  // Map each source to its module mask bit
  genvar g;
  generate
    for (g = 0; g < N_SRC; g++) begin : g_src
      assign src_gate[g] = module_mask[src_mask_bit(g)];
    end
  endgenerate

  // Disabled sources still flag but never reach pend
  assign pend = flags & src_enable & src_gate;

  // Control register: global enable, in-service, spare field
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      global_irq_enable  <= 1'b0;
      control_bit5_field <= 1'b0;
    end else if (ctrl_wr) begin
      global_irq_enable  <= reg_req.wdata[GIE_BIT];
      control_bit5_field <= reg_req.wdata[SPARE_BIT];
    end
  end

  // In-service: set on take, cleared by return; take wins
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      in_service_flag <= 1'b0;
    end else if (irq_take) begin
      in_service_flag <= 1'b1;
    end else if (return_from_handler_instr) begin
      in_service_flag <= 1'b0;
    end else if (ctrl_wr) begin
      in_service_flag <= reg_req.wdata[SERVICE_BIT];
    end
  end

  // Module mask register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      module_mask <= BYTE_RST;
    end else if (mask_wr) begin
      module_mask <= reg_req.wdata[7:0];
    end
  end

  // Single shared vector for every source
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      handler_vector <= VECTOR_RST;
    end else if (vec_wr) begin
      handler_vector <= reg_req.wdata;
    end
  end
  assign vector_pc = handler_vector;

  // One request line; nested interrupts blocked while in service
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_req <= 1'b0;
    end else begin
      irq_req <= global_irq_enable && !in_service_flag && (|pend)
                 && stop_state == ST_RUN && !irq_take;
    end
  end

  // Which modules hold an enabled, flagged source
  always_comb begin
    next_ident = BYTE_RST;
    for (int i = 0; i < N_SRC; i++) begin
      if (flags[i] && src_enable[i]) begin
        next_ident[src_mask_bit(i)] = 1'b1;
      end
    end
  end

  // Registered so a read never sees a half-updated module set
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      source_identification <= BYTE_RST;
    end else begin
      source_identification <= next_ident;
    end
  end

  // Stack pointer wraps like the core stack; no overflow trap
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sp           <= '0;
      ret_addr_out <= VECTOR_RST;
    end else if (irq_take) begin
      sp <= sp + SPW'(1);
    end else if (return_from_handler_instr) begin
      sp           <= sp - SPW'(1);
      ret_addr_out <= stack_mem[sp - SPW'(1)];
    end
  end

  // Stack storage holds data only, so it carries no reset
  always_ff @(posedge clk) begin
    if (irq_take) begin
      stack_mem[sp] <= ret_addr_in;
    end
    // Bottom slot shadow; data only, like the stack itself
    if (irq_take && sp == '0) begin
      bottom_push <= ret_addr_in;
    end
  end

  // Enabled external interrupt wakes from stop
  assign wake = |(ext_rise & src_enable[N_EXT-1:0]) && module_mask[M0_BIT];

  // Stop sequencer; this logic sits on the always-on clock
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      stop_state <= ST_RUN;
      warm_cnt   <= '0;
    end else begin
      unique case (stop_state)
        ST_RUN: begin
          if (stop_set) begin
            stop_state <= ST_HALT;
          end else if (warm_cnt != '0) begin
            warm_cnt <= warm_cnt - WCW'(1);
          end
        end
        ST_HALT: begin
          if (wake) begin
            warm_cnt   <= WCW'(WARMUP_CYCLES);
            stop_state <= xtal_wait ? ST_WARM : ST_RUN;
          end
        end
        ST_WARM: begin
          if (warm_cnt == WCW'(1)) begin
            warm_cnt   <= '0;
            stop_state <= ST_RUN;
          end else begin
            warm_cnt <= warm_cnt - WCW'(1);
          end
        end
      endcase
    end
  end

  // Halt indication and RC-run indication as registered outputs
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      clocks_halted <= 1'b0;
      on_rc_osc     <= 1'b0;
    end else begin
      clocks_halted <= stop_state != ST_RUN;
      on_rc_osc     <= stop_state == ST_RUN && warm_cnt != '0;
    end
  end

  // Read port, registered; unmapped reads return zero
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= '0;
    end else if (reg_req.rd) begin
      reg_rdata <= '0;
      if (reg_req.modsel == MOD_SYS && reg_req.idx == IDX_CTRL) begin
        reg_rdata[GIE_BIT]  <= global_irq_enable;
        reg_rdata[SERVICE_BIT] <= in_service_flag;
        reg_rdata[SPARE_BIT]   <= control_bit5_field;
      end else if (reg_req.modsel == MOD_SYS && reg_req.idx == IDX_MASK) begin
        reg_rdata[7:0] <= module_mask;
      end else if (reg_req.modsel == MOD_SYS && reg_req.idx == IDX_IDENT) begin
        reg_rdata[7:0] <= source_identification;
      end else if (reg_req.modsel == MOD_VEC && reg_req.idx == IDX_VECTOR) begin
        reg_rdata <= handler_vector;
      end
    end
  end

  // Checks kept beside the logic they guard
  a_req_needs_gie: assert property (@(posedge clk) disable iff (!rstn)
    irq_req |-> $past(global_irq_enable) && $past(|pend))
    else $error("request without enable or pending flag");

  a_flag_sticky_set: assert property (@(posedge clk) disable iff (!rstn)
    events[0] |=> flags[0])
    else $error("event did not set its flag");

  a_clear_drops_req: assert property (@(posedge clk) disable iff (!rstn)
    (|flag_clear && (flags & ~flag_clear) == '0 && events == '0) |-> ##2 !irq_req)
    else $error("request stayed after full clear");

  a_vector_reset: assert property (@(posedge clk) disable iff (!rstn)
    $rose(rstn) |-> vector_pc == VECTOR_RST)
    else $error("vector not zero after reset");

  a_vec_write: assert property (@(posedge clk) disable iff (!rstn)
    vec_wr |=> vector_pc == $past(reg_req.wdata))
    else $error("vector write lost");

  a_ident_ext: assert property (@(posedge clk) disable iff (!rstn)
    (|(flags[N_EXT-1:0] & src_enable[N_EXT-1:0])) |=> source_identification[M0_BIT])
    else $error("identification misses module 0");

  a_stack_round: assert property (@(posedge clk) disable iff (!rstn)
    (return_from_handler_instr && !irq_take && sp == SPW'(1)) |=> ret_addr_out == bottom_push)
    else $error("popped address differs from pushed");

  a_no_req_halted: assert property (@(posedge clk) disable iff (!rstn)
    stop_state == ST_HALT |=> !irq_req)
    else $error("request while stopped");

  a_wake_leaves: assert property (@(posedge clk) disable iff (!rstn)
    (stop_state == ST_HALT && wake) |=> stop_state != ST_HALT)
    else $error("enabled external interrupt did not wake");

  a_rc_resume: assert property (@(posedge clk) disable iff (!rstn)
    (stop_state == ST_HALT && wake && !xtal_wait) |=> ##1 on_rc_osc)
    else $error("no immediate resume on RC");

  a_ins_blocks: assert property (@(posedge clk) disable iff (!rstn)
    in_service_flag |=> !irq_req)
    else $error("request while in service");

  a_take_drops_req: assert property (@(posedge clk) disable iff (!rstn)
    irq_take |=> !irq_req)
    else $error("request stayed after take");

  a_warm_on_xtal: assert property (@(posedge clk) disable iff (!rstn)
    (stop_state == ST_HALT && wake && xtal_wait) |=> stop_state == ST_WARM)
    else $error("no crystal warm-up after wake");

  a_halt_holds: assert property (@(posedge clk) disable iff (!rstn)
    (stop_state == ST_HALT && !wake) |=> stop_state == ST_HALT)
    else $error("left stop without enabled external interrupt");

  a_ident_system: assert property (@(posedge clk) disable iff (!rstn)
    (flags[SRC_WDOG] && src_enable[SRC_WDOG]) |=> source_identification[SYS_BIT])
    else $error("identification misses system module");

endmodule : single_vector_interrupt_unit
`default_nettype wire

// ### tb/core_model.sv
`timescale 1ns/1ps
`default_nettype none
module core_model (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        irq_req,
  input  wire logic        accept,
  input  wire logic [3:0]  lag,
  output logic             irq_take,
  output logic [15:0]      ret_addr_in
);
  logic [3:0] wait_cnt;  // Cycles the request has been seen

  // Takes a standing request after lag cycles, one-cycle pulse
  always @(negedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_take <= 1'b0;
      wait_cnt <= 4'h0;
      ret_addr_in <= 16'h0100;
    end else begin
      // Address wanders every cycle; only meaningful with the take
      ret_addr_in <= ret_addr_in + 16'h1357;
      irq_take <= 1'b0;
      if (irq_req && accept && !irq_take) begin
        if (wait_cnt == lag) begin
          irq_take <= 1'b1;
          wait_cnt <= 4'h0;
        end else begin
          wait_cnt <= wait_cnt + 4'h1;
        end
      end else begin
        wait_cnt <= 4'h0;  // Request gone, restart the wait
      end
    end
  end
endmodule : core_model
`default_nettype wire

// ### tb/test_single_vector_interrupt_unit.sv
`timescale 1ns/1ps
`default_nettype none
module test_single_vector_interrupt_unit;
  import irq_unit_pkg::*;
  logic              clk, rstn, irq_take, return_from_handler_instr, stop_set, xtal_wait, accept, took;
  reg_req_t          reg_req;
  logic [15:0]       reg_rdata, ret_addr_in, vector_pc, ret_addr_out, vec;
  logic [N_EXT-1:0]  ext_pin;
  logic [N_INT-1:0]  int_event;
  logic [N_SRC-1:0]  src_enable, flag_clear, flags;
  logic              irq_req, clocks_halted, on_rc_osc;
  logic [3:0]        lag;
  logic [1:0]        rd_d, ret_hist;  // Strobe history for the watcher
  logic [15:0]       rd_q[$], ret_q[$];  // Expected reads and returns
  int                n_mismatch, check_count, k, r, n;

  single_vector_interrupt_unit #(.WARMUP_CYCLES(16)) i_dut (
    .clk(clk), .rstn(rstn), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .ext_pin(ext_pin), .int_event(int_event), .src_enable(src_enable),
    .flag_clear(flag_clear), .irq_take(irq_take), .ret_addr_in(ret_addr_in),
    .return_from_handler_instr(return_from_handler_instr), .stop_set(stop_set),
    .xtal_wait(xtal_wait), .irq_req(irq_req),
    .vector_pc(vector_pc), .ret_addr_out(ret_addr_out), .flags(flags),
    .clocks_halted(clocks_halted), .on_rc_osc(on_rc_osc));
  core_model i_core (.clk(clk), .rstn(rstn), .irq_req(irq_req), .accept(accept),
    .lag(lag), .irq_take(irq_take), .ret_addr_in(ret_addr_in));

  // 125 MHz clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_word

  task automatic chk_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_bit

  task automatic results();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : results

  // Watcher: a result appears two edges after its strobe
  always @(posedge clk) begin
    rd_d <= {rd_d[0], reg_req.rd};
    ret_hist <= {ret_hist[0], return_from_handler_instr};
    if (irq_take) begin
      ret_q.push_back(ret_addr_in);
      took <= 1'b1;
    end
  end
  always @(negedge clk) begin
    if (rd_d[1]) chk_word(reg_rdata, rd_q.pop_front());
    if (ret_hist[1]) chk_word(ret_addr_out, ret_q.pop_front());
  end

  // Register access, one strobe; reads then add a quiet cycle
  task automatic rd(input logic [3:0] m, input logic [4:0] i, input logic [15:0] e);
    @(negedge clk);
    reg_req.rd = 1'b1;
    reg_req.modsel = m;
    reg_req.idx = i;
    rd_q.push_back(e);
    @(negedge clk);
    reg_req.rd = 1'b0;
    @(negedge clk);
  endtask : rd

  task automatic wr(input logic [3:0] m, input logic [4:0] i, input logic [15:0] d);
    @(negedge clk);
    reg_req.wr = 1'b1;
    reg_req.modsel = m;
    reg_req.idx = i;
    reg_req.wdata = d;
    @(negedge clk);
    reg_req.wr = 1'b0;
  endtask : wr

  // Pins need sync plus edge detect, events are one-cycle pulses
  task automatic raise(input int s);
    if (s < N_EXT) begin
      ext_pin[s] = 1'b1;
      repeat (5) @(negedge clk);
      ext_pin[s] = 1'b0;
    end else begin
      int_event[s-N_EXT] = 1'b1;
      @(negedge clk);
      int_event = '0;
      repeat (2) @(negedge clk);
    end
  endtask : raise

  task automatic clr(input int s);
    flag_clear[s] = 1'b1;
    @(negedge clk);
    flag_clear = '0;
    repeat (2) @(negedge clk);
  endtask : clr

  // Hang guard, far beyond the few hundred cycles expected
  initial begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    results();
  end

  initial begin
    void'($urandom(32'hbc89));
    {rstn, return_from_handler_instr, stop_set, xtal_wait, accept, took, lag} = '0;
    {reg_req, ext_pin, int_event, src_enable, flag_clear, rd_d, ret_hist} = '0;
    repeat (4) @(negedge clk);
    rstn = 1'b1;
    repeat (2) @(negedge clk);
    rd(MOD_VEC, IDX_VECTOR, VECTOR_RST);
    rd(MOD_SYS, IDX_CTRL, 16'h0000);
    rd(MOD_SYS, IDX_MASK, 16'h0000);
    vec = 16'($urandom);
    wr(MOD_VEC, IDX_VECTOR, vec);
    rd(MOD_VEC, IDX_VECTOR, vec);
    wr(MOD_SYS, 5'h1f, 16'hffff);
    rd(MOD_SYS, 5'h1f, 16'h0000);
    // Spare control field is stored; enable and in-service stay off
    wr(MOD_SYS, IDX_CTRL, 16'hfffc);
    rd(MOD_SYS, IDX_CTRL, 16'h0020);
    // Every source flags while all enables are off
    for (k = 0; k < N_SRC; k++) begin
      raise(k);
      chk_bit(flags[k], 1'b1);
      chk_bit(irq_req, 1'b0);
      clr(k);
      chk_bit(flags[k], 1'b0);
    end
    // Module mask gates, identification ignores it
    src_enable = '1;
    wr(MOD_SYS, IDX_MASK, 16'h003f);
    wr(MOD_SYS, IDX_CTRL, 16'h0001);
    raise(SRC_WDOG);
    rd(MOD_SYS, IDX_IDENT, 16'h0080);
    chk_bit(flags[SRC_WDOG], 1'b1);
    chk_bit(irq_req, 1'b0);
    wr(MOD_SYS, IDX_MASK, 16'h00bf);
    repeat (2) @(negedge clk);
    chk_bit(irq_req, 1'b1);
    flag_clear[SRC_WDOG] = 1'b1;
    @(negedge clk);
    flag_clear = '0;
    @(negedge clk);
    chk_bit(irq_req, 1'b0);
    // Full take and return, prompt then slow core
    accept = 1'b1;
    for (r = 0; r < 2; r++) begin
      lag = 4'(r * 3);
      k = N_EXT + int'($urandom_range(N_INT - 1));
      took = 1'b0;
      raise(k);
      for (n = 0; n < 30 && took !== 1'b1; n++) @(negedge clk);
      chk_bit(took, 1'b1);
      chk_word(vector_pc, vec);
      rd(MOD_SYS, IDX_CTRL, 16'h0003);
      clr(k);
      return_from_handler_instr = 1'b1;
      @(negedge clk);
      return_from_handler_instr = 1'b0;
      rd(MOD_SYS, IDX_CTRL, 16'h0001);
    end
    // Stop, ignore internal event, wake on a pin, both resume styles
    accept = 1'b0;
    wr(MOD_SYS, IDX_CTRL, 16'h0000);
    for (r = 0; r < 2; r++) begin
      xtal_wait = r[0];
      stop_set = 1'b1;
      @(negedge clk);
      stop_set = 1'b0;
      repeat (3) @(negedge clk);
      chk_bit(clocks_halted, 1'b1);
      raise(SRC_WDOG);
      chk_bit(clocks_halted, 1'b1);
      ext_pin[3] = 1'b1;
      repeat (8) @(negedge clk);
      ext_pin[3] = 1'b0;
      chk_bit(clocks_halted, r[0]);
      chk_bit(on_rc_osc, !r[0]);
      repeat (20) @(negedge clk);
      chk_bit(clocks_halted, 1'b0);
      chk_bit(on_rc_osc, 1'b0);
      clr(3);
      clr(SRC_WDOG);
    end
    // Reset again mid-run: written registers must return to zero
    rstn = 1'b0;
    repeat (4) @(negedge clk);
    rstn = 1'b1;
    repeat (2) @(negedge clk);
    rd(MOD_VEC, IDX_VECTOR, VECTOR_RST);
    rd(MOD_SYS, IDX_MASK, 16'h0000);
    chk_bit(irq_req, 1'b0);
    repeat (3) @(negedge clk);
    results();
  end
endmodule : test_single_vector_interrupt_unit
`default_nettype wire
